// *** hw/ihz_pkg.sv ***
/*
 * ihz_pkg: constants and types used by the dual-issue hazard
 * control (ihz_issue); its register wait table (ihz_score) takes parameters.
 * Assumes one core clock; all waits are counted in core cycles.
 */
`default_nettype none

package ihz_pkg;

    localparam int RW   = 4;                    // Register index width
    localparam int NREG = 16;                   // Architectural registers per thread
    localparam int CW   = 4;                    // Wait counter width
    localparam int CLW  = 4;                    // Class code width

    // Instruction classes as decoded by the front end
    typedef enum logic [3:0] {
        CL_ALU    = 4'h0,
        CL_SHI    = 4'h1,                       // Shift, immediate count
        CL_SHC    = 4'h2,                       // Shift, count register
        CL_MUL    = 4'h3,
        CL_LONG   = 4'h4,
        CL_HEAVY  = 4'h5,                       // Divide or both-port operation
        CL_LEA    = 4'h6,                       // Address compute
        CL_STACK  = 4'h7,                       // Push, pop, call, return
        CL_LOAD   = 4'h8,
        CL_STORE  = 4'h9,
        CL_XFER   = 4'ha,                       // int_to_vector_move, word_insert_op
        CL_BRANCH = 4'hb
    } ihz_cls_t;

    localparam logic [3:0] SP_REG       = 4'h4; // stack_pointer index
    localparam logic [3:0] COUNT_REG    = 4'h1; // Shift count register index
    localparam logic [3:0] WAIT_SHC     = 4'h2; // Three-cycle shift latency
    localparam logic [3:0] WAIT_MUL     = 4'h4; // Five-cycle multiply latency
    localparam logic [3:0] WAIT_LONG    = 4'h5;
    localparam logic [3:0] AGU_PEN      = 4'h3; // Execution-to-address penalty
    localparam logic [3:0] NARROW_EXTRA = 4'h1; // Narrow input slowdown
    localparam logic [1:0] FLAG_AGE_ISS = 2'h1; // Age one cycle after producer
    localparam logic [1:0] FLAG_GAP     = 2'h2; // Non-branch reader spacing
    localparam logic [1:0] TAKE_ONE     = 2'h1;
    localparam logic [1:0] TAKE_TWO     = 2'h2;

endpackage : ihz_pkg

`default_nettype wire

// *** hw/ihz_score.sv ***
/*
 * ihz_score: per-register wait counters for one thread, one for
 * execution consumers and one for address-unit consumers.
 * Assumes the two write ports never name the same register in one
 * cycle; if they do, port 1 (the younger) wins.
 */
`default_nettype none

module ihz_score #(
    parameter int NR = 16,
    parameter int AW = 4,
    parameter int CW = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic [1:0]        i_we,
    input  wire logic [2*AW-1:0]   i_dst,
    input  wire logic [2*CW-1:0]   i_exe_wait,
    input  wire logic [2*CW-1:0]   i_agu_wait,
    output logic      [NR-1:0]     o_exe_rdy,
    output logic      [NR-1:0]     o_agu_rdy
);

    ////////////////////////////////////////////////////////////////////
    // One pair of counters per full register; byte halves share it
    genvar r;
    for (r = 0; r < NR; r++)
    begin : g_reg
        logic [CW-1:0] exe_r;
        logic [CW-1:0] agu_r;
        logic [CW-1:0] exe_nxt;
        logic [CW-1:0] agu_nxt;
        wire           hit0 = i_we[0] && (i_dst[AW-1:0] == AW'(r));
        wire           hit1 = i_we[1] && (i_dst[2*AW-1:AW] == AW'(r));

        // Load on issue, else drain to zero
        assign exe_nxt = hit1 ? i_exe_wait[2*CW-1:CW] :
                         hit0 ? i_exe_wait[CW-1:0] :
                         (exe_r != '0) ? exe_r - 1'b1 : exe_r;
        assign agu_nxt = hit1 ? i_agu_wait[2*CW-1:CW] :
                         hit0 ? i_agu_wait[CW-1:0] :
                         (agu_r != '0) ? agu_r - 1'b1 : agu_r;
        assign o_exe_rdy[r] = (exe_r == '0);
        assign o_agu_rdy[r] = (agu_r == '0);

        // Counter state
        always_ff @(posedge i_clk or negedge i_resetn)
        begin
            if (!i_resetn)
            begin
                exe_r <= '0;
                agu_r <= '0;
            end
            else
            begin
                exe_r <= exe_nxt;
                agu_r <= agu_nxt;
            end
        end
    end

endmodule : ihz_score

`default_nettype wire

// *** hw/ihz_issue.sv ***
/*
 * ihz_issue: issue and interlock control for a two-wide in-order
 * core running two threads. Each thread offers its two oldest queue
 * slots; up to two instructions go out per cycle, one per port.
 * Assumes the queue pops o_take entries per thread one cycle after
 * the decision, and shows unchanged slots in the cycle of the pop.
 */
// Notes on behaviour
// (RL1) Up to two instructions issue per cycle, one on each port.
// (RL2) A flag reader never issues together with a flag writer.
// (RL3) A branch reading flags may issue the cycle after the producer.
// (RL4) Other flag readers issue no earlier than two cycles after the producer.
// (RL5) Long instructions keep younger short ones of their thread waiting.
// (RL6) A long instruction holds short ones of both threads one cycle.
// (RL7) Two instructions with one destination never issue together.
// (RL8) Heavy instructions wait until oldest, issue alone, stall younger.
// (RL9) Address use of an execution result waits three extra cycles.
// (RL10) Stack operations read the stack pointer through the address unit.
// (RL11) Address compute runs on the address unit with the same penalty.
// (RL12) Integer-to-vector moves use the address unit, same penalty.
// (RL13) Multiply is pipelined alongside other long instructions.
// (RL14) Short instructions do not pass an executing multiply.
// (RL15) An independent multiply may follow one cycle after another.
// (RL16) Immediate-count shifts have one-cycle latency.
// (RL17) Count-register shifts have three-cycle latency.
// (RL18) Partial writes cost nothing extra but track the whole register.
// (RL19) Low and high byte parts share one full-register dependency.
// (RL20) Narrow inputs slow address compute, loads and pops.
// (RL21) Threads take turns for first pick; either port may be used.
// (RL22) Loads and stores use port 0; address compute and stack port 1.
// (RL23) Every hazard is enforced by holding issue, never by software.
`default_nettype none

module ihz_issue #(
    parameter int         RW          = ihz_pkg::RW,
    parameter int         NREG        = ihz_pkg::NREG,
    parameter logic [3:0] P_WAIT_MUL  = ihz_pkg::WAIT_MUL,
    parameter logic [3:0] P_WAIT_LONG = ihz_pkg::WAIT_LONG
) (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic [3:0]        i_vld,
    input  wire logic [15:0]       i_cls,
    input  wire logic [4*RW-1:0]   i_dst,
    input  wire logic [3:0]        i_dst_we,
    input  wire logic [4*RW-1:0]   i_src_a,
    input  wire logic [3:0]        i_src_a_en,
    input  wire logic [4*RW-1:0]   i_src_b,
    input  wire logic [3:0]        i_src_b_en,
    input  wire logic [3:0]        i_rd_flags,
    input  wire logic [3:0]        i_wr_flags,
    input  wire logic [3:0]        i_narrow,
    input  wire logic [1:0]        i_oldest,
    output logic                   o_p0_vld,
    output logic                   o_p0_thr,
    output logic      [3:0]        o_p0_cls,
    output logic      [RW-1:0]     o_p0_dst,
    output logic                   o_p1_vld,
    output logic                   o_p1_thr,
    output logic      [3:0]        o_p1_cls,
    output logic      [RW-1:0]     o_p1_dst,
    output logic      [3:0]        o_take
);

    localparam int CW  = ihz_pkg::CW;
    localparam int CLW = ihz_pkg::CLW;

    ////////////////////////////////////////////////////////////////////
    // Class decoding used in several places
    function automatic logic f_agu(input ihz_pkg::ihz_cls_t k);
        return k == ihz_pkg::CL_LEA || k == ihz_pkg::CL_STACK ||
               k == ihz_pkg::CL_LOAD || k == ihz_pkg::CL_STORE ||
               k == ihz_pkg::CL_XFER;                       // [RL11] [RL12]
    endfunction : f_agu

    function automatic logic f_long(input ihz_pkg::ihz_cls_t k);
        return k == ihz_pkg::CL_MUL || k == ihz_pkg::CL_LONG;
    endfunction : f_long

    // Multiply is not short, so it pipelines beside long ones
    function automatic logic f_short(input ihz_pkg::ihz_cls_t k);
        return !f_long(k) && k != ihz_pkg::CL_HEAVY;        // [RL13]
    endfunction : f_short

    function automatic logic f_need0(input ihz_pkg::ihz_cls_t k);
        return k == ihz_pkg::CL_LOAD || k == ihz_pkg::CL_STORE;
    endfunction : f_need0

    function automatic logic f_need1(input ihz_pkg::ihz_cls_t k);
        return k == ihz_pkg::CL_LEA || k == ihz_pkg::CL_STACK;
    endfunction : f_need1

    // Cycles a dependent execution consumer must wait after issue
    function automatic logic [3:0] f_wait(input ihz_pkg::ihz_cls_t k,
                                          input logic nar);
        logic [3:0] w;
        case (k)
            ihz_pkg::CL_SHC:   w = ihz_pkg::WAIT_SHC;        // [RL17]
            ihz_pkg::CL_MUL:   w = P_WAIT_MUL;
            ihz_pkg::CL_LONG,
            ihz_pkg::CL_HEAVY: w = P_WAIT_LONG;
            default:           w = 4'h0;                     // [RL16]
        endcase
        if (nar && (k == ihz_pkg::CL_LEA || k == ihz_pkg::CL_LOAD ||
                    k == ihz_pkg::CL_STACK))
            w = w + ihz_pkg::NARROW_EXTRA;                   // [RL20]
        return w;
    endfunction : f_wait

    ////////////////////////////////////////////////////////////////////
    // State and per-candidate signals
    logic                rr_r;
    logic                hold_r;
    logic [1:0]          take_r [2];
    logic [1:0]          take_nxt [2];
    logic [1:0]          flag_age_r [2];
    logic [1:0]          flag_age_nxt [2];
    logic [CW-1:0]       blk_r [2];
    logic [CW-1:0]       blk_nxt [2];
    logic [NREG-1:0]     exe_rdy [2];
    logic [NREG-1:0]     agu_rdy [2];
    logic [1:0]          heavy_wait;
    logic [3:0]          c_vld, c_ok, c_dwe, c_ea, c_eb;
    logic [3:0]          c_rdf, c_wrf, c_nar, iss;
    ihz_pkg::ihz_cls_t   c_cls [4];
    logic [RW-1:0]       c_dst [4], c_sa [4], c_sb [4];
    logic [CW-1:0]       c_ew [4], c_aw [4];
    logic [1:0]          iss_wrf, iss_rdnb, iss_rdbr;
    logic [1:0]          iss_short, iss_long, iss_mul;

    ////////////////////////////////////////////////////////////////////
    // Candidates: index = thread*2 + age. After a single pop the queue
    // has not shifted yet, so the younger slot stands in as the head.
    genvar c;
    for (c = 0; c < 4; c++)
    begin : g_cand
        localparam int T = c / 2;
        localparam int K = c % 2;
        wire       sh   = (take_r[T] == ihz_pkg::TAKE_ONE);
        wire       live = (take_r[T] != ihz_pkg::TAKE_TWO) && !(K == 1 && sh);
        wire [1:0] q    = (K == 1 || sh) ? 2'(T * 2 + 1) : 2'(T * 2);
        wire       address_unit;
        wire       ra, rb, rimp, rflg, rblk, rhvy;

        assign c_vld[c] = live && i_vld[q];
        assign c_cls[c] = ihz_pkg::ihz_cls_t'(i_cls[q*CLW +: CLW]);
        assign c_dst[c] = i_dst[q*RW +: RW];                 // [RL18] [RL19]
        assign c_sa[c]  = i_src_a[q*RW +: RW];
        assign c_sb[c]  = i_src_b[q*RW +: RW];
        assign c_dwe[c] = i_dst_we[q];
        assign c_ea[c]  = i_src_a_en[q];
        assign c_eb[c]  = i_src_b_en[q];
        assign c_rdf[c] = i_rd_flags[q];
        assign c_wrf[c] = i_wr_flags[q];
        assign c_nar[c] = i_narrow[q];
        assign address_unit      = f_agu(c_cls[c]);

        // Address-side readers of execution results pay the penalty
        assign c_ew[c]  = f_wait(c_cls[c], c_nar[c]);
        assign c_aw[c]  = c_ew[c] + (address_unit ? 4'h0 : ihz_pkg::AGU_PEN); // [RL9]

        // Operand, flag and blocking checks; failure holds issue
        assign ra   = !c_ea[c] || (address_unit ? agu_rdy[T][c_sa[c]]
                                       : exe_rdy[T][c_sa[c]]); // [RL11] [RL12]
        assign rb   = !c_eb[c] || exe_rdy[T][c_sb[c]];
        assign rimp = (c_cls[c] == ihz_pkg::CL_SHC)   ? exe_rdy[T][ihz_pkg::COUNT_REG] :
                      (c_cls[c] == ihz_pkg::CL_STACK) ? agu_rdy[T][ihz_pkg::SP_REG] :
                      1'b1;                                  // [RL10] [RL17]
        assign rflg = !c_rdf[c] || ((c_cls[c] == ihz_pkg::CL_BRANCH) ?
                      (flag_age_r[T] >= ihz_pkg::FLAG_AGE_ISS) :  // [RL3]
                      (flag_age_r[T] >= ihz_pkg::FLAG_GAP));      // [RL4]
        assign rblk = !f_short(c_cls[c]) ||
                      (!hold_r && blk_r[T] == '0);           // [RL5] [RL6] [RL14]
        assign rhvy = ((c_cls[c] != ihz_pkg::CL_HEAVY) ||
                       (K == 0 && !sh && i_oldest[T])) &&
                      !heavy_wait[1-T];                      // [RL8]
        assign c_ok[c] = c_vld[c] && ra && rb && rimp && rflg &&
                         rblk && rhvy;                       // [RL23]
    end

    ////////////////////////////////////////////////////////////////////
    // Selection: first pick from the favoured thread's head, else the other thread's head, then one
    // compatible partner. Pairing is greedy, so an older pick never
    // waits to let a better pair form.
    wire [1:0] cp0 = {rr_r, 1'b0};                          // [RL21]
    wire [1:0] cq0 = {!rr_r, 1'b0};
    wire       fv  = c_ok[cp0] || c_ok[cq0];
    wire [1:0] fc  = c_ok[cp0] ? cp0 : cq0;
    logic [1:0] pair_ok;

    genvar j;
    for (j = 0; j < 2; j++)
    begin : g_pair
        wire [1:0] b    = (j == 0) ? {fc[1], 1'b1} : cq0;
        wire       same = (fc[1] == b[1]);
        wire       raw  = same && c_dwe[fc] &&
                          ((c_ea[b] && c_sa[b] == c_dst[fc]) ||
                           (c_eb[b] && c_sb[b] == c_dst[fc]) ||
                           (c_cls[b] == ihz_pkg::CL_SHC && c_dst[fc] == ihz_pkg::COUNT_REG) ||
                           (c_cls[b] == ihz_pkg::CL_STACK && c_dst[fc] == ihz_pkg::SP_REG));
        wire       waw  = c_dwe[fc] && c_dwe[b] && c_dst[fc] == c_dst[b]; // [RL7]
        wire       flg  = (c_wrf[fc] && c_rdf[b]) ||
                          (c_wrf[b] && c_rdf[fc]);          // [RL2]
        wire       prt  = (f_need0(c_cls[fc]) && f_need0(c_cls[b])) ||
                          (f_need1(c_cls[fc]) && f_need1(c_cls[b])); // [RL22]
        wire       lng  = same && f_long(c_cls[fc]) && f_short(c_cls[b]); // [RL5]
        wire       mm   = c_cls[fc] == ihz_pkg::CL_MUL &&
                          c_cls[b] == ihz_pkg::CL_MUL;       // [RL15]
        wire       hv   = c_cls[fc] == ihz_pkg::CL_HEAVY ||
                          c_cls[b] == ihz_pkg::CL_HEAVY;     // [RL8]
        assign pair_ok[j] = fv && c_ok[b] && !raw && !waw && !flg &&
                            !prt && !lng && !mm && !hv;
    end

    // Partner and port assignment
    wire       xv   = pair_ok[0] || (pair_ok[1] && fc == cp0); // [RL1]
    wire [1:0] xc   = pair_ok[0] ? {fc[1], 1'b1} : cq0;
    wire       f_p1 = f_need1(c_cls[fc]) ||
                      (xv && f_need0(c_cls[xc]));          // [RL22]
    wire       p0v  = f_p1 ? xv : fv;
    wire       p1v  = f_p1 ? fv : xv;
    wire [1:0] p0c  = f_p1 ? xc : fc;
    wire [1:0] p1c  = f_p1 ? fc : xc;

    for (c = 0; c < 4; c++)
    begin : g_iss
        assign iss[c] = (fv && fc == 2'(c)) || (xv && xc == 2'(c));
    end

    ////////////////////////////////////////////////////////////////////
    // Clock and reset for every check below, the per-thread ones too
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    ////////////////////////////////////////////////////////////////////
    // Per-thread wait table, flag age and long-latency block
    genvar t;
    for (t = 0; t < 2; t++)
    begin : g_thr
        wire l0 = iss[t*2] && f_long(c_cls[t*2]);
        wire l1 = iss[t*2+1] && f_long(c_cls[t*2+1]);

        ihz_score #(
            .NR (NREG),
            .AW (RW),
            .CW (CW)
        ) u_score (
            .i_clk      (i_clk),
            .i_resetn   (i_resetn),
            .i_we       ({iss[t*2+1] && c_dwe[t*2+1], iss[t*2] && c_dwe[t*2]}),
            .i_dst      ({c_dst[t*2+1], c_dst[t*2]}),
            .i_exe_wait ({c_ew[t*2+1], c_ew[t*2]}),
            .i_agu_wait ({c_aw[t*2+1], c_aw[t*2]}),
            .o_exe_rdy  (exe_rdy[t]),
            .o_agu_rdy  (agu_rdy[t])
        );

        assign heavy_wait[t] = c_vld[t*2] && take_r[t] == 2'h0 && i_oldest[t] &&
                               c_cls[t*2] == ihz_pkg::CL_HEAVY;
        assign iss_wrf[t]  = (iss[t*2] && c_wrf[t*2]) || (iss[t*2+1] && c_wrf[t*2+1]);
        assign iss_rdnb[t] = (iss[t*2] && c_rdf[t*2] && c_cls[t*2] != ihz_pkg::CL_BRANCH) ||
                             (iss[t*2+1] && c_rdf[t*2+1] &&
                              c_cls[t*2+1] != ihz_pkg::CL_BRANCH);
        assign iss_rdbr[t] = (iss[t*2] && c_rdf[t*2] && c_cls[t*2] == ihz_pkg::CL_BRANCH) ||
                             (iss[t*2+1] && c_rdf[t*2+1] &&
                              c_cls[t*2+1] == ihz_pkg::CL_BRANCH);
        assign iss_short[t] = (iss[t*2] && f_short(c_cls[t*2])) ||
                              (iss[t*2+1] && f_short(c_cls[t*2+1]));
        assign iss_long[t]  = l0 || l1;
        assign iss_mul[t]   = (iss[t*2] && c_cls[t*2] == ihz_pkg::CL_MUL) ||
                              (iss[t*2+1] && c_cls[t*2+1] == ihz_pkg::CL_MUL);

        // Age saturates at the full non-branch spacing
        assign flag_age_nxt[t] = iss_wrf[t] ? ihz_pkg::FLAG_AGE_ISS :
                                 (flag_age_r[t] == ihz_pkg::FLAG_GAP) ? ihz_pkg::FLAG_GAP :
                                 flag_age_r[t] + 2'h1;       // [RL4]
        assign blk_nxt[t] = l1 ? c_ew[t*2+1] : l0 ? c_ew[t*2] :
                            (blk_r[t] != '0) ? blk_r[t] - 4'h1 : blk_r[t]; // [RL14]
        assign take_nxt[t] = {iss[t*2+1], iss[t*2] && !iss[t*2+1]};

        chk_flag_gap: assert property (iss_wrf[t] |=> !iss_rdnb[t]) // [RL4]
            else $error("flag reader issued one cycle after its producer");
        chk_mul_block: assert property (iss_mul[t] |=> !iss_short[t] [*4]) // [RL14]
            else $error("short instruction passed a running multiply");
    end

    ////////////////////////////////////////////////////////////////////
    // Registered state and outputs
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rr_r     <= 1'b0;
            hold_r   <= 1'b0;
            o_p0_vld <= 1'b0;
            o_p0_thr <= 1'b0;
            o_p0_cls <= 4'h0;
            o_p0_dst <= '0;
            o_p1_vld <= 1'b0;
            o_p1_thr <= 1'b0;
            o_p1_cls <= 4'h0;
            o_p1_dst <= '0;
            o_take   <= 4'h0;
            for (int i = 0; i < 2; i++)
            begin
                take_r[i]     <= 2'h0;
                flag_age_r[i] <= ihz_pkg::FLAG_GAP;
                blk_r[i]      <= '0;
            end
        end
        else
        begin
            rr_r     <= fv ? !fc[1] : rr_r;                // [RL21]
            hold_r   <= |iss_long;                         // [RL6]
            o_p0_vld <= p0v;
            o_p0_thr <= p0c[1];
            o_p0_cls <= c_cls[p0c];
            o_p0_dst <= c_dst[p0c];
            o_p1_vld <= p1v;
            o_p1_thr <= p1c[1];
            o_p1_cls <= c_cls[p1c];
            o_p1_dst <= c_dst[p1c];
            o_take   <= {take_nxt[1], take_nxt[0]};
            for (int i = 0; i < 2; i++)
            begin
                take_r[i]     <= take_nxt[i];
                flag_age_r[i] <= flag_age_nxt[i];
                blk_r[i]      <= blk_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks on the issue decision
    chk_dst_pair: assert property (p0v && p1v && c_dwe[p0c] && c_dwe[p1c] // [RL7]
                                   |-> c_dst[p0c] != c_dst[p1c])
        else $error("two writers of one destination issued together");
    chk_flag_same: assert property (p0v && p1v |-> // [RL2]
                                    !(c_wrf[p0c] && c_rdf[p1c]) &&
                                    !(c_wrf[p1c] && c_rdf[p0c]))
        else $error("flag reader paired with flag writer");
    chk_long_hold: assert property (|iss_long |=> !(|iss_short)) // [RL6]
        else $error("short instruction issued right after a long one");
    chk_port_mem: assert property (p1v |-> !f_need0(c_cls[p1c])) // [RL22]
        else $error("memory access sent to port 1");
    chk_port_agu: assert property (p0v |-> !f_need1(c_cls[p0c])) // [RL22]
        else $error("address compute or stack op sent to port 0");
    chk_heavy_alone: assert property (p0v && c_cls[p0c] == ihz_pkg::CL_HEAVY // [RL8]
                                      |-> !p1v && i_oldest[p0c[1]])
        else $error("heavy instruction not alone or not oldest");
    chk_out_dual: assert property (p0v && p1v |=> o_p0_vld && o_p1_vld && // [RL1]
                                   o_p0_thr == $past(p0c[1]) && o_take != 4'h0)
        else $error("dual issue decision not presented on the ports");

    cov_dual: cover property (p0v && p1v);
    cov_heavy: cover property (p0v && c_cls[p0c] == ihz_pkg::CL_HEAVY);
    cov_branch_next: cover property (iss_wrf[0] ##1 iss_rdbr[0]);
    cov_mul_pair: cover property (iss_mul[0] ##1 iss_mul[0]);

endmodule : ihz_issue

`default_nettype wire

// *** tb/ihz_queue_model.sv ***
/* ihz_queue_model: two-thread instruction queue at the issue inputs.
   Assumes the issue logic takes slots only while they are valid. */
`default_nettype none
module ihz_queue_model (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [3:0]  i_take,
    output logic      [3:0]  o_vld,
    output logic      [16:0] o_slot [4],
    output logic      [1:0]  o_oldest
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [16:0] q0 [$];
    logic [16:0] q1 [$];
    logic        tg_r;
    task push(input logic t, input logic [16:0] v);
        if (t) q1.push_back(v); else q0.push_back(v);
    endtask : push
    // Pop on o_take, show shifted heads next cycle; empty slots churn
    always @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            q0.delete();
            q1.delete();
            tg_r <= 1'b0;
            o_vld <= 4'h0;
            o_slot <= '{default: 17'h00000};
            o_oldest <= 2'h0;
        end
        else
        begin
            tg_r <= ~tg_r;
            repeat (i_take[1:0]) void'(q0.pop_front());
            repeat (i_take[3:2]) void'(q1.pop_front());
            for (int a = 0; a < 2; a++)
            begin
                o_vld[a] <= q0.size() > a;
                o_vld[a+2] <= q1.size() > a;
                o_slot[a] <= (q0.size() > a) ? q0[a] : {17{tg_r}};
                o_slot[a+2] <= (q1.size() > a) ? q1[a] : {17{~tg_r}};
            end
            o_oldest <= (q0.size() != 0) ? 2'h1 : {q1.size() != 0, 1'b0};
        end
    end
endmodule : ihz_queue_model
`default_nettype wire

// *** tb/ihz_issue_test.sv ***
/* ihz_issue_test: pairs of thread-0 instructions, judged by issue spacing.
   Assumes the queue model pops on o_take as the issue logic expects. */
`default_nettype none
module ihz_issue_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk;
    logic        i_resetn;
    logic [3:0]  take, vld, we, sae, rdf, wrf, nar;
    logic [16:0] slot [4];
    logic [1:0]  oldest;
    logic [15:0] cls, dst, sa;
    logic        p0v, p1v;
    logic [3:0]  p0c, p1c;
    int          failures = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          lc [$];
    logic [3:0]  lk [$];
    // Unpack each slot into the per-field buses
    always_comb
        for (int q = 0; q < 4; q++)
            {cls[q*4+:4], dst[q*4+:4], we[q], sa[q*4+:4], sae[q], rdf[q], wrf[q], nar[q]} = slot[q];
    ihz_queue_model ihz_queue_model_inst (.i_clk, .i_resetn, .i_take(take), .o_vld(vld),
        .o_slot(slot), .o_oldest(oldest));
    ihz_issue ihz_issue_inst (.i_clk, .i_resetn, .i_vld(vld), .i_cls(cls), .i_dst(dst),
        .i_dst_we(we), .i_src_a(sa), .i_src_a_en(sae), .i_src_b(16'h0000),
        .i_src_b_en(4'h0), .i_rd_flags(rdf), .i_wr_flags(wrf), .i_narrow(nar),
        .i_oldest(oldest), .o_p0_vld(p0v), .o_p0_thr(), .o_p0_cls(p0c), .o_p0_dst(),
        .o_p1_vld(p1v), .o_p1_thr(), .o_p1_cls(p1c), .o_p1_dst(), .o_take(take));
    ////////////////////////////////////////////////////////////////////////
    // Log issue cycles, port 0 first; the ceiling catches a hung queue
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (p0v === 1'b1) begin lc.push_back(cyc); lk.push_back(p0c); end
        if (p1v === 1'b1) begin lc.push_back(cyc); lk.push_back(p1c); end
        if (cyc > 3000) begin failures++; end_sim(); end
    end
    function automatic logic [16:0] ins(logic [3:0] c, d, a, logic [2:0] f);
        return {c, d, d != 4'h0, a, a != 4'h0, f};  // Flags: read, write, narrow
    endfunction : ins
    task chk_gap(input int got, input int exp);
        n_compared++;
        if (got != exp) begin failures++; $display("CHECK FAILED %0t gap %0d", $time, got); end
    endtask : chk_gap
    task chk_cls(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin failures++; $display("CHECK FAILED %0t port 0 class", $time); end
    endtask : chk_cls
    // Second instruction must issue exp cycles after the first
    task pair(input logic [16:0] a, input logic [16:0] b, input int exp);
        lc.delete();
        lk.delete();
        ihz_queue_model_inst.push(1'b0, a);
        ihz_queue_model_inst.push(1'b0, b);
        for (int i = 0; i < 40 && lc.size() < 2; i++) @(posedge i_clk);
        repeat (10) @(posedge i_clk);
        chk_gap(lc.size() >= 2 ? lc[1] - lc[0] : -1, exp);
    endtask : pair
    task t_dual;
        pair(ins(ihz_pkg::CL_ALU, 4'h3, 4'h0, 3'h0), ins(ihz_pkg::CL_LOAD, 4'h2, 4'h0, 3'h0), 0);
        chk_cls(lk[0], ihz_pkg::CL_LOAD);
    endtask : t_dual
    task t_flags;
        pair(ins(ihz_pkg::CL_ALU, 4'h2, 4'h0, 3'h2), ins(ihz_pkg::CL_BRANCH, 4'h0, 4'h0, 3'h4), 1);
        pair(ins(ihz_pkg::CL_ALU, 4'h2, 4'h0, 3'h2), ins(ihz_pkg::CL_ALU, 4'h3, 4'h0, 3'h4), 2);
    endtask : t_flags
    task t_long;
        pair(ins(ihz_pkg::CL_MUL, 4'h2, 4'h0, 3'h0), ins(ihz_pkg::CL_ALU, 4'h3, 4'h0, 3'h0), 5);
        pair(ins(ihz_pkg::CL_MUL, 4'h2, 4'h0, 3'h0), ins(ihz_pkg::CL_MUL, 4'h3, 4'h0, 3'h0), 1);
        pair(ins(ihz_pkg::CL_LONG, 4'h2, 4'h0, 3'h0), ins(ihz_pkg::CL_ALU, 4'h3, 4'h0, 3'h0), 6);
        pair(ins(ihz_pkg::CL_ALU, 4'h2, 4'h0, 3'h0), ins(ihz_pkg::CL_ALU, 4'h2, 4'h0, 3'h0), 1);
    endtask : t_long
    task t_agu;
        pair(ins(ihz_pkg::CL_ALU, 4'h2, 4'h0, 3'h0), ins(ihz_pkg::CL_LEA, 4'h3, 4'h2, 3'h0), 4);
        pair(ins(ihz_pkg::CL_ALU, 4'h4, 4'h0, 3'h0), ins(ihz_pkg::CL_STACK, 4'h5, 4'h4, 3'h0), 4);
        pair(ins(ihz_pkg::CL_ALU, 4'h2, 4'h0, 3'h0), ins(ihz_pkg::CL_XFER, 4'h3, 4'h2, 3'h0), 4);
        pair(ins(ihz_pkg::CL_LEA, 4'h2, 4'h0, 3'h1), ins(ihz_pkg::CL_ALU, 4'h3, 4'h2, 3'h0), 2);
        pair(ins(ihz_pkg::CL_SHI, 4'h2, 4'h0, 3'h0), ins(ihz_pkg::CL_ALU, 4'h3, 4'h2, 3'h0), 1);
        pair(ins(ihz_pkg::CL_SHC, 4'h2, 4'h0, 3'h0), ins(ihz_pkg::CL_ALU, 4'h3, 4'h2, 3'h0), 3);
    endtask : t_agu
    task end_sim;
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Clock at 50 ns
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // Reset for 12 cycles, then the scenarios
    initial
    begin
        i_resetn = 1'b0;
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        t_dual();
        t_flags();
        t_long();
        t_agu();
        end_sim();
    end
endmodule : ihz_issue_test
`default_nettype wire
